//--- logic/ect_top.sv
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module ect_top
    import ect_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic SHARED_PIN_I,
    output logic SHARED_PIN_O,
    output logic SHARED_PIN_OE,
    input wire logic CMP_OUT,
    output logic TOUT_O,
    output logic TOUT_OE,
    output logic IRQ
);
    ect_bus_if bus();

    logic [CTRL_W-1:0] ctrl_reg;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [15:0] reload_reg;
    logic [15:0] capture_reg;
    logic [7:0] hold_reg;
    logic [6:0] pre_cnt_reg;
    logic armed_reg;
    logic out_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] irq_set;
    logic [31:0] wmask;
    logic [31:0] rd_word;
    logic rd_hit;
    logic enabled;
    logic polarity;
    logic pin_in_en;
    logic pin_out_en;
    ect_mode_t mode;
    logic [2:0] pre_sel;
    logic pin_edge_raw;
    logic cmp_edge_raw;
    logic pin_edge;
    logic pre_tick;
    logic tick;
    logic reload_hit;
    logic capture_hit;
    logic wr_ctrl;
    logic wr_cnt_hi;
    logic wr_cnt_lo;
    logic wr_rld_hi;
    logic wr_rld_lo;

    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    function automatic logic addr_mapped(input logic [7:0] a);
        logic hit;
        hit = 1'b0;
        case (a)
            OFS_CTRL, OFS_CNT_HI, OFS_CNT_LO, OFS_RLD_HI, OFS_RLD_LO,
            OFS_CAPT, OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_STATE: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    ect_axil u_axil (
        .clk(CLK),
        .rst_n(RST_N),
        .awaddr(AWADDR),
        .awvalid(AWVALID),
        .awready(AWREADY),
        .wdata(WDATA),
        .wstrb(WSTRB),
        .wvalid(WVALID),
        .wready(WREADY),
        .bresp(BRESP),
        .bvalid(BVALID),
        .bready(BREADY),
        .araddr(ARADDR),
        .arvalid(ARVALID),
        .arready(ARREADY),
        .rdata(RDATA),
        .rresp(RRESP),
        .rvalid(RVALID),
        .rready(RREADY),
        .bus(bus.slave)
    );

    ect_edge u_pin_edge (
        .clk(CLK),
        .rst_n(RST_N),
        .async_in(SHARED_PIN_I),
        .rise_sel(polarity),
        .edge_hit(pin_edge_raw)
    );

    ect_edge u_cmp_edge (
        .clk(CLK),
        .rst_n(RST_N),
        .async_in(CMP_OUT),
        .rise_sel(polarity),
        .edge_hit(cmp_edge_raw)
    );

    // control fields
    assign enabled = ctrl_reg[CTRL_EN];
    assign mode = ect_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
    assign polarity = ctrl_reg[CTRL_POL];
    assign pre_sel = ctrl_reg[CTRL_PRE_LSB +: 3];
    assign pin_in_en = ctrl_reg[CTRL_IN_EN];
    assign pin_out_en = ctrl_reg[CTRL_OUT_EN];

    // write decode
    assign wmask = strb_mask(bus.wr_strb);
    assign bus.wr_hit = addr_mapped(bus.wr_addr);
    assign wr_ctrl = bus.wr_en && bus.wr_addr == OFS_CTRL;
    assign wr_cnt_hi = bus.wr_en && bus.wr_addr == OFS_CNT_HI && bus.wr_strb[0];
    assign wr_cnt_lo = bus.wr_en && bus.wr_addr == OFS_CNT_LO && bus.wr_strb[0];
    assign wr_rld_hi = bus.wr_en && bus.wr_addr == OFS_RLD_HI && bus.wr_strb[0];
    assign wr_rld_lo = bus.wr_en && bus.wr_addr == OFS_RLD_LO && bus.wr_strb[0];

    // the shared pin only feeds the counter when assigned and not in paired PWM
    assign pin_edge = pin_edge_raw && pin_in_en && mode != ECT_MODE_DUAL;

    // prescale factor is 2 to the power of the select field
    assign pre_tick = pre_cnt_reg == 7'((8'h01 << pre_sel) - 8'h01);

    always_comb begin
        tick = 1'b0;
        if (enabled) begin
            unique case (mode)
                ECT_MODE_COUNT: tick = pin_edge;
                ECT_MODE_CMP: tick = cmp_edge_raw;
                ECT_MODE_CAPTURE: tick = armed_reg && pre_tick;
                ECT_MODE_DUAL: tick = pre_tick;
            endcase
        end
    end

    assign reload_hit = tick && count_reg == reload_reg;
    // later edges capture; the arming edge does not
    assign capture_hit = enabled && mode == ECT_MODE_CAPTURE && armed_reg && pin_edge;

    always_comb begin
        count_next = count_reg;
        if (reload_hit) begin
            count_next = CNT_RESTART;
        end else if (tick) begin
            count_next = count_reg + 16'h0001;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ctrl_reg <= CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_reg <= (ctrl_reg & ~wmask[CTRL_W-1:0]) | (bus.wr_data[CTRL_W-1:0] & wmask[CTRL_W-1:0]);
        end
    end

    // a software write to either byte overrides only that byte; the other byte still takes the counted value
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            count_reg <= CNT_RST;
        end else if (wr_cnt_hi) begin
            count_reg <= {bus.wr_data[7:0], count_next[7:0]};
        end else if (wr_cnt_lo) begin
            count_reg <= {count_next[15:8], bus.wr_data[7:0]};
        end else begin
            count_reg <= count_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            reload_reg <= RLD_RST;
        end else if (wr_rld_hi) begin
            reload_reg[15:8] <= bus.wr_data[7:0];
        end else if (wr_rld_lo) begin
            reload_reg[7:0] <= bus.wr_data[7:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pre_cnt_reg <= 7'h00;
        end else if (!enabled || mode == ECT_MODE_CMP || pre_tick) begin
            pre_cnt_reg <= 7'h00;
        end else if (mode != ECT_MODE_CAPTURE || armed_reg) begin
            pre_cnt_reg <= pre_cnt_reg + 7'h01;
        end
    end

    // capture waits for the first qualifying input edge
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            armed_reg <= 1'b0;
        end else if (!enabled || mode != ECT_MODE_CAPTURE) begin
            armed_reg <= 1'b0;
        end else if (pin_edge) begin
            armed_reg <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            capture_reg <= 16'h0000;
        end else if (capture_hit) begin
            capture_reg <= count_reg;
        end
    end

    // output idles at the polarity level while disabled
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            out_reg <= 1'b0;
        end else if (!enabled) begin
            out_reg <= polarity;
        end else if (reload_hit) begin
            out_reg <= ~out_reg;
        end
    end

    // coherent read while enabled: upper byte read freezes lower byte
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            hold_reg <= 8'h00;
        end else if (bus.rd_en && bus.rd_addr == OFS_CNT_HI && enabled) begin
            hold_reg <= count_reg[7:0];
        end
    end

    assign irq_set = {IRQ_W{1'b0}} | (IRQ_W'(reload_hit) << IRQ_RELOAD) | (IRQ_W'(capture_hit) << IRQ_CAPT);

    // write-one-to-clear; a new event in the same cycle wins
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            irq_stat_reg <= {IRQ_W{1'b0}};
        end else if (bus.wr_en && bus.wr_addr == OFS_IRQ_STAT && bus.wr_strb[0]) begin
            irq_stat_reg <= (irq_stat_reg & ~bus.wr_data[IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            irq_mask_reg <= {IRQ_W{1'b0}};
        end else if (bus.wr_en && bus.wr_addr == OFS_IRQ_MASK && bus.wr_strb[0]) begin
            irq_mask_reg <= bus.wr_data[IRQ_W-1:0];
        end
    end

    assign IRQ = |(irq_stat_reg & irq_mask_reg);

    // reads only change the holding byte, never the counting path
    always_comb begin
        rd_word = 32'h00000000;
        rd_hit = addr_mapped(bus.rd_addr);
        case (bus.rd_addr)
            OFS_CTRL: rd_word[CTRL_W-1:0] = ctrl_reg;
            OFS_CNT_HI: rd_word[7:0] = count_reg[15:8];
            OFS_CNT_LO: rd_word[7:0] = enabled ? hold_reg : count_reg[7:0];
            OFS_RLD_HI: rd_word[7:0] = reload_reg[15:8];
            OFS_RLD_LO: rd_word[7:0] = reload_reg[7:0];
            OFS_CAPT: rd_word[15:0] = capture_reg;
            OFS_IRQ_STAT: rd_word[IRQ_W-1:0] = irq_stat_reg;
            OFS_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask_reg;
            OFS_STATE: rd_word[2:0] = {enabled, armed_reg, out_reg};
            default: rd_word = 32'h00000000;
        endcase
    end

    assign bus.rd_data = rd_word;
    assign bus.rd_hit = rd_hit;

    // pins
    assign TOUT_O = out_reg;
    assign TOUT_OE = pin_out_en;
    assign SHARED_PIN_O = ~out_reg;
    assign SHARED_PIN_OE = pin_out_en && mode == ECT_MODE_DUAL;
endmodule

//--- logic/ect_pkg.sv
package ect_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CNT_HI = 8'h04;
    localparam logic [7:0] OFS_CNT_LO = 8'h08;
    localparam logic [7:0] OFS_RLD_HI = 8'h0C;
    localparam logic [7:0] OFS_RLD_LO = 8'h10;
    localparam logic [7:0] OFS_CAPT = 8'h14;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
    localparam logic [7:0] OFS_STATE = 8'h20;
    localparam int CTRL_EN = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_POL = 3;
    localparam int CTRL_PRE_LSB = 4;
    localparam int CTRL_IN_EN = 7;
    localparam int CTRL_OUT_EN = 8;
    localparam int CTRL_W = 9;
    localparam int IRQ_RELOAD = 0;
    localparam int IRQ_CAPT = 1;
    localparam int IRQ_W = 2;
    localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
    localparam logic [15:0] CNT_RST = 16'h0001;
    localparam logic [15:0] CNT_RESTART = 16'h0001;
    localparam logic [15:0] RLD_RST = 16'hFFFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    typedef enum logic [1:0] {
        ECT_MODE_COUNT,
        ECT_MODE_CMP,
        ECT_MODE_CAPTURE,
        ECT_MODE_DUAL
    } ect_mode_t;
endpackage

//--- logic/ect_bus_if.sv
`timescale 1ns/1ps
interface ect_bus_if;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;
    logic rd_en;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_hit;
    modport slave(output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input wr_hit, rd_data, rd_hit);
    modport regs(input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output wr_hit, rd_data, rd_hit);
endinterface

//--- logic/ect_edge.sv
`timescale 1ns/1ps
module ect_edge
    import ect_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    input wire logic rise_sel,
    output logic edge_hit
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign edge_hit = rise_sel ? (sync_reg & ~last_reg) : (~sync_reg & last_reg);
endmodule

//--- logic/ect_axil.sv
`timescale 1ns/1ps
module ect_axil
    import ect_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    ect_bus_if.slave bus
);
    logic aw_full_reg;
    logic w_full_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;

    assign awready = ~aw_full_reg;
    assign wready = ~w_full_reg;
    assign arready = ~rvalid;
    assign bus.wr_en = aw_full_reg & w_full_reg & ~bvalid;
    assign bus.wr_addr = aw_addr_reg;
    assign bus.wr_data = w_data_reg;
    assign bus.wr_strb = w_strb_reg;
    assign bus.rd_en = arvalid & ~rvalid;
    assign bus.rd_addr = araddr;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (awvalid && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= awaddr;
        end else if (bus.wr_en) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end else if (wvalid && !w_full_reg) begin
            w_full_reg <= 1'b1;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
        end else if (bus.wr_en) begin
            w_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (bus.wr_en) begin
            bvalid <= 1'b1;
            bresp <= bus.wr_hit ? RESP_OKAY : RESP_DECERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end else if (bus.rd_en) begin
            rvalid <= 1'b1;
            rdata <= bus.rd_data;
            rresp <= bus.rd_hit ? RESP_OKAY : RESP_DECERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule

//--- verif/ect_asserts.sv
`timescale 1ns/1ps
module ect_asserts (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic SHARED_PIN_O,
    input wire logic SHARED_PIN_OE,
    input wire logic TOUT_O,
    input wire logic TOUT_OE,
    input wire logic IRQ
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    sequence wr_taken;
        AWVALID && AWREADY && WVALID && WREADY;
    endsequence

    a_out_compl: assert property (SHARED_PIN_O == !TOUT_O)
        else $error("shared pin output is not the inverse of the timer output");
    a_oe_dual: assert property (SHARED_PIN_OE |-> TOUT_OE)
        else $error("shared pin driven without output enable");
    a_irq_cause: assert property ($rose(IRQ) |-> $changed(TOUT_O) || $rose(BVALID))
        else $error("interrupt rose without reload or register write");
    a_write_lat: assert property (wr_taken |=> !BVALID ##1 BVALID)
        else $error("write response not two edges after address and data");
    a_ready_low: assert property (wr_taken |=> (!AWREADY && !WREADY) ##1 (AWREADY && WREADY))
        else $error("write channels not ready again with the response");
    a_bvalid_drop: assert property (BVALID && BREADY |=> !BVALID)
        else $error("write response held after handshake");
    a_rvalid_drop: assert property (RVALID && RREADY |=> !RVALID)
        else $error("read data held after handshake");
    a_read_lat: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read data not one edge after address");
    a_ar_busy: assert property (ARREADY == !RVALID)
        else $error("read address ready while data pending");

    c_irq: cover property ($rose(IRQ));
    c_toggle: cover property ($changed(TOUT_O));
    c_pin_drive: cover property (SHARED_PIN_OE);
endmodule

bind ect_top ect_asserts u_chk (.CLK(CLK), .RST_N(RST_N), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .SHARED_PIN_O(SHARED_PIN_O),
    .SHARED_PIN_OE(SHARED_PIN_OE), .TOUT_O(TOUT_O), .TOUT_OE(TOUT_OE), .IRQ(IRQ));

//--- verif/ect_src_model.sv
`timescale 1ns/1ps
// signal source: flips the pin or comparator line num times, gap clocks apart
module ect_src_model #(
    parameter int GAP = 6
) (
    input wire logic clk,
    input wire logic go,
    input wire logic sel_cmp,
    input wire logic [3:0] num,
    output logic pin,
    output logic cmp,
    output logic busy
);
    initial begin
        pin = 1'b0;
        cmp = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                busy <= 1'b1;
                repeat (num) begin
                    repeat (GAP) @(posedge clk);
                    if (sel_cmp)
                        cmp <= !cmp;
                    else
                        pin <= !pin;
                end
                busy <= 1'b0;
            end
        end
    end
endmodule

//--- verif/tb.sv
`timescale 1ns/1ps
`define CHK(a, e) \
    begin \
        samples_checked++; \
        if ((a) !== (e)) begin \
            num_errors++; \
            $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); \
        end \
    end
module tb
    import ect_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n, awvalid, wvalid, bready, arvalid, rready, go, sel, lp, lc;
    logic awready, wready, bvalid, arready, rvalid, pin, cmp, busy, pin_o, pin_oe, tout, tout_oe, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rdat;
    logic [3:0] wstrb, num;
    logic [1:0] resp, bresp, rresp;
    int num_errors, samples_checked, cyc, cc, t_last;
    wire pad = pin_oe ? pin_o : pin;

    ect_top dut (.CLK(clk), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
        .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .SHARED_PIN_I(pad), .SHARED_PIN_O(pin_o),
        .SHARED_PIN_OE(pin_oe), .CMP_OUT(cmp), .TOUT_O(tout), .TOUT_OE(tout_oe), .IRQ(irq));
    ect_src_model u_src (.clk(clk), .go(go), .sel_cmp(sel), .num(num), .pin(pin), .cmp(cmp), .busy(busy));

    initial forever #12.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    function automatic logic [31:0] ctl(input logic [1:0] m, input logic p, input logic e);
        return {23'h0, 2'h3, (m == 2'h2) ? 3'h1 : 3'h7, p, m, e};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        bready <= 1'b1;
        do @(posedge clk); while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge clk); while (!rvalid);
        rdat = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    // pin edges need sync and edge detect before the count moves
    task automatic edges(input logic [3:0] n, input logic c);
        go <= 1'b1;
        sel <= c;
        num <= n;
        @(posedge clk);
        go <= 1'b0;
        do @(posedge clk); while (busy);
        t_last = cyc;
        repeat (8) @(posedge clk);
    endtask

    task automatic t_regs();
        rd(OFS_CTRL);
        `CHK(rdat, 32'h0)
        `CHK(resp, RESP_OKAY)
        rd(OFS_CNT_LO);
        `CHK(rdat, 32'h1)
        rd(OFS_RLD_HI);
        `CHK(rdat, 32'hFF)
        rd(8'h40);
        `CHK(resp, RESP_DECERR)
        `CHK(rdat, 32'h0)
        wr(8'h40, 32'h1);
        `CHK(resp, RESP_DECERR)
    endtask

    task automatic t_count(input logic p, input logic c);
        logic l;
        int n, nr;
        wr(OFS_IRQ_STAT, 32'h3);
        wr(OFS_CTRL, ctl({1'b0, c}, p, 1'b0));
        // output follows the new polarity one edge after the control write lands
        @(posedge clk);
        `CHK(tout, p)
        wr(OFS_CNT_HI, 32'h0);
        wr(OFS_CNT_LO, 32'h1);
        wr(OFS_RLD_HI, 32'h0);
        wr(OFS_RLD_LO, 32'h4);
        wr(OFS_IRQ_MASK, 32'h1);
        wr(OFS_CTRL, ctl({1'b0, c}, p, 1'b1));
        edges(4'h9, c);
        l = c ? lc : lp;
        n = 1;
        nr = 0;
        repeat (9) begin
            l = !l;
            if (l == p) begin
                n = (n == 4) ? 1 : n + 1;
                nr += (n == 1);
            end
        end
        lc = c ? l : lc;
        lp = c ? lp : l;
        cc = n;
        rd(OFS_CNT_HI);
        `CHK(rdat, 32'h0)
        rd(OFS_CNT_LO);
        `CHK(rdat, 32'(n))
        `CHK(tout, p ^ nr[0])
        `CHK(irq, nr != 0)
        rd(OFS_IRQ_STAT);
        `CHK(rdat, 32'(nr != 0))
    endtask

    task automatic t_hold();
        rd(OFS_CNT_HI);
        edges(4'h2, 1'b0);
        rd(OFS_CNT_LO);
        `CHK(rdat, 32'(cc))
        wr(OFS_CTRL, ctl(2'h0, 1'b1, 1'b0));
        rd(OFS_CNT_LO);
        `CHK(rdat, 32'((cc == 4) ? 1 : cc + 1))
    endtask

    task automatic t_capture();
        int el;
        wr(OFS_IRQ_MASK, 32'h0);
        wr(OFS_CTRL, ctl(2'h2, 1'b1, 1'b0));
        wr(OFS_CNT_HI, 32'h0);
        wr(OFS_CNT_LO, 32'h1);
        wr(OFS_RLD_HI, 32'hFF);
        wr(OFS_RLD_LO, 32'hFF);
        wr(OFS_IRQ_STAT, 32'h3);
        wr(OFS_CTRL, ctl(2'h2, 1'b1, 1'b1));
        rd(OFS_CNT_HI);
        rd(OFS_CNT_LO);
        `CHK(rdat, 32'h1)
        edges(lp ? 4'h2 : 4'h1, 1'b0);
        el = t_last;
        rd(OFS_IRQ_STAT);
        `CHK(rdat, 32'h0)
        edges(4'h2, 1'b0);
        el = t_last - el;
        lp = 1'b1;
        rd(OFS_CAPT);
        `CHK(((rdat - 1) * 2 + 3 >= el) && ((rdat - 1) * 2 <= el + 3), 1'b1)
        rd(OFS_IRQ_STAT);
        `CHK(rdat, 32'h2)
        rd(OFS_STATE);
        `CHK(rdat, 32'h7)
    endtask

    task automatic t_pwm();
        wr(OFS_CTRL, ctl(2'h3, 1'b1, 1'b1));
        `CHK(pin_oe, 1'b1)
        `CHK(tout_oe, 1'b1)
        wr(OFS_CTRL, ctl(2'h0, 1'b1, 1'b1));
        `CHK(pin_oe, 1'b0)
    endtask

    task automatic results();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready, go, sel, lp, lc} = '0;
        {awaddr, araddr, wdata, num} = '0;
        wstrb = 4'hF;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_count(1'b1, 1'b0);
        t_hold();
        t_count(1'b0, 1'b0);
        t_count(1'b1, 1'b1);
        t_count(1'b0, 1'b1);
        t_capture();
        t_pwm();
        results();
    end

    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        results();
    end
endmodule
